// ---- src/rxwb_pkg.sv ----
// Purpose: Constants for the receive descriptor status writeback block
// Assumes: Avalon-MM register bus, 32-bit data, word addresses in bytes
// Notes: Header word layout is fixed here; offsets of registers are local choices
package rxwb_pkg;
    // ============================================================
    // Register byte offsets
    localparam logic [7:0] RXWB_ADDR_HIGH_OFS = 8'h00;
    localparam logic [7:0] RXWB_ADDR_LOW_OFS = 8'h04;
    localparam logic [7:0] RXWB_QCOUNT_OFS = 8'h08;
    localparam logic [7:0] RXWB_MODE_OFS = 8'h0C;
    localparam logic [7:0] RXWB_STATUS_OFS = 8'h10;
    localparam logic [7:0] RXWB_QPOP_OFS = 8'h14;
    localparam logic [7:0] RXWB_QHEAD_LO_OFS = 8'h18;
    localparam logic [7:0] RXWB_QHEAD_HI_OFS = 8'h1C;
    // ============================================================
    // Mode register bit positions
    localparam int RXWB_MODE_OVERSIZE_PERMIT = 0;
    localparam int RXWB_MODE_PASS_ERR = 1;
    localparam int RXWB_MODE_VLAN_EN = 2;
    localparam int RXWB_MODE_VLAN_TABLE_EN = 3;
    localparam int RXWB_MODE_IP_CHK = 4;
    localparam int RXWB_MODE_TCP_CHK = 5;
    localparam int RXWB_MODE_UDP_CHK = 6;
    localparam logic [6:0] RXWB_MODE_RESET = 7'h00;
    // ============================================================
    // Header word 0 field positions
    localparam int RXWB_H_LEN_LSB = 0;
    localparam int RXWB_H_FCNT_LSB = 16;
    localparam int RXWB_H_LENERR = 22;
    localparam int RXWB_H_STATION = 23;
    localparam int RXWB_H_BCAST = 24;
    localparam int RXWB_H_MCAST = 25;
    localparam int RXWB_H_OVERSIZE = 26;
    localparam int RXWB_H_OVERFLOW = 27;
    localparam int RXWB_H_CRC = 28;
    localparam int RXWB_H_RUNT = 29;
    localparam int RXWB_H_ALIGN = 30;
    localparam int RXWB_H_SUMMARY = 31;
    // Header word 1 field positions
    localparam int RXWB_H_VIDX_LSB = 0;
    localparam int RXWB_H_VHIT = 8;
    localparam int RXWB_H_IPERR = 10;
    localparam int RXWB_H_TCPERR = 11;
    localparam int RXWB_H_UDPERR = 12;
    localparam int RXWB_H_IPPRES = 13;
    localparam int RXWB_H_TCPPRES = 14;
    localparam int RXWB_H_UDPPRES = 15;
    // ============================================================
    // Sizes and reset values
    localparam int RXWB_QDEPTH = 8;
    localparam int RXWB_QPTR_W = 3;
    localparam logic [31:0] RXWB_WORD_RESET = 32'h0000_0000;
    localparam logic [3:0] RXWB_QCOUNT_RESET = 4'h0;
    localparam logic [31:0] RXWB_UNMAPPED_DATA = 32'h0000_0000;
endpackage

// ---- src/rxwb_status_writeback.sv ----
// Purpose: Rewrites a receive descriptor header after frame delivery, and queues
//          64-bit descriptor addresses written by software.
// Assumes: Frame classifier, MAC and checksum engines report results on rx_done;
//          fragment fields and header inputs are from the same clock.
// Notes: Bus answers every access one cycle after it is seen (waitrequest high once).
// What this block does
// - After delivery, rewrite header with length, status
// - Length field reports true frame length
// - Fragment count copied from host value
// - Station match flag on own address
// - Broadcast flag on all-ones destination
// - Multicast flag when filter passes frame
// - Oversize flag; error only when permit is off and pass-error is on
// - Overflow: store what fits, flag error
// - CRC error flag on check mismatch
// - Runt flag on short frame
// - Alignment flag on non-octet length
// - Length flag when payload below length field
// - Summary error ORs errors, plus oversize case
// - VLAN hit needs both enables and match
// - VLAN index names matching entry when hit
// - IP checksum error only when enabled, present
// - TCP checksum error only when enabled, present
// - UDP checksum error only when enabled, present
// - Header-present flags always reported
// - Fragment address/length copied unchanged
// - Reserved header fields written as zero
// - Upper address write only stages, no command
// - Upper first; lower write queues, counts
//
// The Avalon-MM interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module rxwb_status_writeback
    import rxwb_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Frame results from the receive path
    input wire logic rx_done,
    input wire logic [15:0] rx_frame_length,
    input wire logic [15:0] rx_bytes_stored,
    input wire logic [15:0] rx_buffer_space,
    input wire logic [5:0] fragment_count,
    input wire logic [31:0] fragment_address,
    input wire logic [15:0] fragment_length,
    input wire logic da_is_station,
    input wire logic da_is_broadcast,
    input wire logic mcast_pass,
    input wire logic frame_oversize,
    input wire logic crc_mismatch,
    input wire logic frame_runt,
    input wire logic frame_misaligned,
    input wire logic payload_short,
    input wire logic vlan_match,
    input wire logic [7:0] vlan_match_index,
    input wire logic ip_header_present,
    input wire logic tcp_header_present,
    input wire logic udp_header_present,
    input wire logic ip_checksum_bad,
    input wire logic tcp_checksum_bad,
    input wire logic udp_checksum_bad,
    // Header writeback
    output logic hdr_valid,
    output logic [31:0] hdr_word0,
    output logic [31:0] hdr_word1,
    output logic [31:0] hdr_frag_address,
    output logic [31:0] hdr_frag_length,
    output logic [15:0] store_length,
    output logic rx_cmd_pending
);
    // ============================================================
    // State
    typedef struct packed {
        logic [31:0] addr_high;
        logic [6:0] mode;
        logic [RXWB_QDEPTH-1:0] [63:0] fifo;
        logic [RXWB_QPTR_W-1:0] wr_ptr;
        logic [RXWB_QPTR_W-1:0] rd_ptr;
        logic [3:0] qcount;
        logic answer;
        logic waitreq;
        logic pending;
        logic [31:0] readdata;
        logic hdr_valid;
        logic [31:0] word0;
        logic [31:0] word1;
        logic [31:0] frag_addr;
        logic [31:0] frag_len;
        logic [15:0] store_len;
        logic [31:0] last_word0;
    } rxwb_state_t;

    rxwb_state_t state_reg;
    rxwb_state_t state_next;

    function automatic logic [31:0] rxwb_mask(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic rxwb_hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    logic oversize_err;
    logic summary;
    logic [31:0] w0;
    logic [31:0] w1;
    logic [63:0] head;

    always_comb begin
        // Oversize counts as error only when not permitted
        oversize_err = frame_oversize && !state_reg.mode[RXWB_MODE_OVERSIZE_PERMIT];
        summary = payload_short | (rx_bytes_stored < rx_frame_length) | crc_mismatch
                  | frame_runt | frame_misaligned
                  | (oversize_err && state_reg.mode[RXWB_MODE_PASS_ERR]);
        w0 = RXWB_WORD_RESET;
        w0[RXWB_H_LEN_LSB +: 16] = rx_frame_length;
        w0[RXWB_H_FCNT_LSB +: 6] = fragment_count;
        w0[RXWB_H_LENERR] = payload_short;
        w0[RXWB_H_STATION] = da_is_station;
        w0[RXWB_H_BCAST] = da_is_broadcast;
        w0[RXWB_H_MCAST] = mcast_pass;
        w0[RXWB_H_OVERSIZE] = frame_oversize;
        w0[RXWB_H_OVERFLOW] = rx_frame_length > rx_buffer_space;
        w0[RXWB_H_CRC] = crc_mismatch;
        w0[RXWB_H_RUNT] = frame_runt;
        w0[RXWB_H_ALIGN] = frame_misaligned;
        w0[RXWB_H_SUMMARY] = summary | w0[RXWB_H_OVERFLOW];
        w1 = RXWB_WORD_RESET;
        w1[RXWB_H_VHIT] = vlan_match && state_reg.mode[RXWB_MODE_VLAN_EN]
                          && state_reg.mode[RXWB_MODE_VLAN_TABLE_EN];
        // Index left zero on miss so software never sees stale entries
        w1[RXWB_H_VIDX_LSB +: 8] = w1[RXWB_H_VHIT] ? vlan_match_index : 8'h00;
        w1[RXWB_H_IPERR] = state_reg.mode[RXWB_MODE_IP_CHK] && ip_header_present
                           && ip_checksum_bad;
        w1[RXWB_H_TCPERR] = state_reg.mode[RXWB_MODE_TCP_CHK] && tcp_header_present
                            && tcp_checksum_bad;
        w1[RXWB_H_UDPERR] = state_reg.mode[RXWB_MODE_UDP_CHK] && udp_header_present
                            && udp_checksum_bad;
        w1[RXWB_H_IPPRES] = ip_header_present;
        w1[RXWB_H_TCPPRES] = tcp_header_present;
        w1[RXWB_H_UDPPRES] = udp_header_present;
        head = state_reg.fifo[state_reg.rd_ptr];

        state_next = state_reg;
        state_next.hdr_valid = 1'b0;
        // ========================================================
        // Header rewrite on frame completion
        if (rx_done) begin
            state_next.hdr_valid = 1'b1;
            state_next.word0 = w0;
            state_next.word1 = w1;
            state_next.last_word0 = w0;
            state_next.frag_addr = fragment_address;
            state_next.frag_len = {16'h0000, fragment_length};
            // Only what fits is stored; the rest is dropped
            state_next.store_len = (rx_frame_length > rx_buffer_space) ? rx_buffer_space
                                   : rx_frame_length;
        end
        // ========================================================
        // Bus slave: one wait cycle, then answer
        state_next.answer = 1'b0;
        if ((avs_read || avs_write) && !state_reg.answer) begin
            // Read data latched here so it stands while waitrequest is low
            state_next.answer = 1'b1;
            state_next.readdata = RXWB_UNMAPPED_DATA;
            if (avs_read) begin
                case (avs_address)
                    RXWB_QCOUNT_OFS: state_next.readdata = {28'h0, state_reg.qcount};
                    RXWB_MODE_OFS: state_next.readdata = {25'h0, state_reg.mode};
                    RXWB_STATUS_OFS: state_next.readdata = state_reg.last_word0;
                    RXWB_QHEAD_LO_OFS: state_next.readdata = head[31:0];
                    RXWB_QHEAD_HI_OFS: state_next.readdata = head[63:32];
                    default: state_next.readdata = RXWB_UNMAPPED_DATA;
                endcase
            end
        end
        // Writes commit only at the edge where waitrequest is seen low
        if (avs_write && state_reg.answer) begin
            if (rxwb_hit(avs_address, RXWB_ADDR_HIGH_OFS)) begin
                // Staging only; no command is started here
                state_next.addr_high = rxwb_mask(state_reg.addr_high, avs_writedata,
                                                 avs_byteenable);
            end else if (rxwb_hit(avs_address, RXWB_ADDR_LOW_OFS)) begin
                // Full queue drops the push rather than overwrite
                if (state_reg.qcount != 4'(RXWB_QDEPTH)) begin
                    state_next.fifo[state_reg.wr_ptr] = {state_reg.addr_high,
                        rxwb_mask(RXWB_WORD_RESET, avs_writedata, avs_byteenable)};
                    state_next.wr_ptr = state_reg.wr_ptr + 3'h1;
                    state_next.qcount = state_reg.qcount + 4'h1;
                end
            end else if (rxwb_hit(avs_address, RXWB_MODE_OFS)) begin
                state_next.mode = 7'(rxwb_mask({25'h0, state_reg.mode}, avs_writedata,
                                               avs_byteenable));
            end else if (rxwb_hit(avs_address, RXWB_QPOP_OFS)) begin
                if (state_reg.qcount != RXWB_QCOUNT_RESET) begin
                    state_next.rd_ptr = state_reg.rd_ptr + 3'h1;
                    state_next.qcount = state_reg.qcount - 4'h1;
                end
            end
        end
        state_next.waitreq = !state_next.answer;
        state_next.pending = state_next.qcount != RXWB_QCOUNT_RESET;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '0;
            // Idle bus stalls until an access is accepted
            state_reg.waitreq <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign avs_readdata = state_reg.readdata;
    assign avs_waitrequest = state_reg.waitreq;
    assign hdr_valid = state_reg.hdr_valid;
    assign hdr_word0 = state_reg.word0;
    assign hdr_word1 = state_reg.word1;
    assign hdr_frag_address = state_reg.frag_addr;
    assign hdr_frag_length = state_reg.frag_len;
    assign store_length = state_reg.store_len;
    assign rx_cmd_pending = state_reg.pending;
endmodule // rxwb_status_writeback

// ---- testbench/rxwb_rx_source.sv ----
// Purpose: Receive path stand-in that hands over frame results on request
// Assumes: The writeback samples results only while rx_done is high
// Notes: Fields change every cycle, so a late sample never matches by luck
`timescale 1ns/1ps
module rxwb_rx_source (
    input wire logic clk,
    input wire logic go,
    output logic rx_done = 1'b0,
    output logic [127:0] res = 128'h0
);
    logic [31:0] seed = 32'h6D46_4EF1;
    always @(posedge clk) begin
        rx_done <= go;
        res <= {$random(seed), $random(seed), $random(seed), $random(seed)};
    end
endmodule // rxwb_rx_source

// ---- testbench/rxwb_status_writeback_checker.sv ----
// Purpose: Port-level checks of the rewritten receive header
// Assumes: One clock; mode register is internal, so mode-gated bits are left to the bench
// Notes: Every check keys off rx_done or hdr_valid, both low through reset
`timescale 1ns/1ps
module rxwb_status_writeback_checker (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic rx_done,
    input wire logic da_is_station,
    input wire logic da_is_broadcast,
    input wire logic mcast_pass,
    input wire logic crc_mismatch,
    input wire logic frame_runt,
    input wire logic vlan_match,
    input wire logic ip_header_present,
    input wire logic hdr_valid,
    input wire logic [31:0] hdr_word0,
    input wire logic [31:0] hdr_word1
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_hdr_follows: assert property (hdr_valid == $past(rx_done)) else $error("Header pulse misplaced");
    a_addr_class: assert property (rx_done |=> hdr_word0[25:23] == $past({mcast_pass, da_is_broadcast, da_is_station}))
        else $error("Address class wrong");
    a_crc_runt: assert property (rx_done |=> hdr_word0[29:28] == $past({frame_runt, crc_mismatch}))
        else $error("Crc or runt flag wrong");
    a_err_summary: assert property (hdr_valid && (|{hdr_word0[30:27], hdr_word0[22]}) |-> hdr_word0[31])
        else $error("Summary error missing");
    a_vlan_hit: assert property (rx_done && !vlan_match |=> !hdr_word1[8]) else $error("Hit without match");
    a_vlan_index: assert property (hdr_valid && !hdr_word1[8] |-> hdr_word1[7:0] == 8'h00)
        else $error("Index set on miss");
    a_ip_present: assert property (rx_done |=> hdr_word1[13] == $past(ip_header_present))
        else $error("Ip present wrong");
    a_reserved_zero: assert property (hdr_valid |-> hdr_word1[31:16] == 16'h0000 && !hdr_word1[9])
        else $error("Reserved bits set");
endmodule // rxwb_status_writeback_checker
bind rxwb_status_writeback rxwb_status_writeback_checker rxwb_status_writeback_checker_inst (
    .clk(clk),
    .reset_n(reset_n),
    .rx_done(rx_done),
    .da_is_station(da_is_station),
    .da_is_broadcast(da_is_broadcast),
    .mcast_pass(mcast_pass),
    .crc_mismatch(crc_mismatch),
    .frame_runt(frame_runt),
    .vlan_match(vlan_match),
    .ip_header_present(ip_header_present),
    .hdr_valid(hdr_valid),
    .hdr_word0(hdr_word0),
    .hdr_word1(hdr_word1)
);

// ---- testbench/test_rx_descriptor_status_writeback.sv ----
// Purpose: Self-checking bench for the receive status writeback block
// Assumes: Each bus access ends within 50 cycles
// Notes: Mode redrawn before each frame, so gated flags see both enable states
`timescale 1ns/1ps
module test_rx_descriptor_status_writeback
    import rxwb_pkg::*;
;
    logic clk = 1'b0, reset_n = 1'b0, go = 1'b0, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, rx_done, hdr_valid;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0000_0000, seed = 32'h6D46_4EF1;
    logic [31:0] avs_readdata, hdr_word0, hdr_word1, hdr_frag_address, hdr_frag_length, q;
    logic [15:0] store_length, stored;
    logic rx_cmd_pending;
    logic [127:0] res, e;
    logic [6:0] mode;
    int mismatches = 0, samples_checked = 0;
    assign stored = (res[15:0] > res[31:16]) ? res[31:16] : res[15:0];
    always #5 clk = ~clk;
    rxwb_rx_source rxwb_rx_source_inst (.clk, .go, .rx_done, .res);
    rxwb_status_writeback rxwb_status_writeback_inst (
        .clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
        .avs_waitrequest, .rx_done, .rx_frame_length(res[15:0]), .rx_bytes_stored(stored),
        .rx_buffer_space(res[31:16]), .fragment_count(res[37:32]), .fragment_address(res[69:38]),
        .fragment_length(res[85:70]), .da_is_station(res[86]), .da_is_broadcast(res[87]), .mcast_pass(res[88]),
        .frame_oversize(res[89]), .crc_mismatch(res[90]), .frame_runt(res[91]), .frame_misaligned(res[92]),
        .payload_short(res[93]), .vlan_match(res[94]), .vlan_match_index(res[108:101]),
        .ip_header_present(res[95]), .tcp_header_present(res[96]), .udp_header_present(res[97]),
        .ip_checksum_bad(res[98]), .tcp_checksum_bad(res[99]), .udp_checksum_bad(res[100]), .hdr_valid,
        .hdr_word0, .hdr_word1, .hdr_frag_address, .hdr_frag_length, .store_length, .rx_cmd_pending
    );
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
            mismatches++;
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        {avs_write, avs_read, avs_address, avs_writedata} <= {wr, ~wr, a, d};
        do @(posedge clk); while (avs_waitrequest !== 1'b0 && ++n < 50);
        q = avs_readdata;
        {avs_write, avs_read} <= 2'b00;
        if (n >= 50) begin
            $display("MISMATCH %0t bus access timed out", $time);
            mismatches++;
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0000_0000);
        chk({96'h0, q}, {96'h0, x});
    endtask
    function automatic logic [127:0] expect_hdr(input logic [127:0] x, input logic [6:0] m);
        logic ovf = x[15:0] > x[31:16];
        logic hit = x[94] & m[2] & m[3];
        return {ovf ? x[31:16] : x[15:0], x[85:38], 16'h0, x[97:95], x[100:98] & x[97:95] & m[6:4], 1'b0, hit,
            hit ? x[108:101] : 8'h00, x[93] | ovf | (|x[92:90]) | (x[89] & ~m[0] & m[1]), x[92:90], ovf, x[89:86],
            x[93], x[37:32], x[15:0]};
    endfunction
    task automatic frame();
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        e = expect_hdr(res, mode);
        @(negedge clk);
        chk({store_length, hdr_frag_length[15:0], hdr_frag_address, hdr_word1, hdr_word0}, e);
    endtask
    task automatic print_verdict();
        $display("Checked %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        bus(1'b1, RXWB_ADDR_HIGH_OFS, 32'hA5A5_0001);
        rd(RXWB_QCOUNT_OFS, 32'h0000_0000);
        chk({127'h0, rx_cmd_pending}, 128'h0);
        bus(1'b1, RXWB_ADDR_LOW_OFS, 32'h1234_5670);
        rd(RXWB_QHEAD_HI_OFS, 32'hA5A5_0001);
        rd(RXWB_QHEAD_LO_OFS, 32'h1234_5670);
        for (int i = 0; i < 16; i++) bus(1'b1, {5'h00, i[0], 2'b00}, $random(seed));
        rd(RXWB_QCOUNT_OFS, 32'h0000_0008);
        chk({127'h0, rx_cmd_pending}, 128'h1);
        for (int i = 0; i < 9; i++) bus(1'b1, RXWB_QPOP_OFS, 32'h0000_0000);
        rd(RXWB_QCOUNT_OFS, 32'h0000_0000);
        chk({127'h0, rx_cmd_pending}, 128'h0);
        rd(8'hF0, RXWB_UNMAPPED_DATA);
        for (int i = 0; i < 40; i++) begin
            mode = (i < 2) ? {7{i[0]}} : 7'($random(seed));
            bus(1'b1, RXWB_MODE_OFS, {25'h0, mode});
            frame();
        end
        rd(RXWB_STATUS_OFS, e[31:0]);
        print_verdict();
    end
    initial begin
        repeat (5000) @(posedge clk);
        $display("MISMATCH %0t run timed out", $time);
        mismatches++;
        print_verdict();
    end
endmodule // test_rx_descriptor_status_writeback
